// File: verilog/spi_eeprom_node_id.v
/*
 * serial-bus side of a 256-byte serial eeprom holding a 6-byte node
 * identifier in its top bytes, with write-protect, pause and block guard.
 * assumes every pin is asynchronous to mclk and sck is far slower than mclk
 * (320 ns against 40 ns), so edges are found after two-flop synchronisers.
 */
// Function
// - six-byte node identifier at 0xFA..0xFF
// - first three bytes organization identifier, rest extension
// - factory guard 01 refuses writes 0xC0..0xFF
// - select low selects, high deselects; standby unless programming runs
// - started programming always completes
// - output released while deselected
// - select rise after valid write starts programming
// - output bit changes after falling clock
// - input bits sampled on rising clock
// - write-protect low refuses array/status writes
// - write-protect low clears write-enable latch
// - running write not aborted by write-protect
// - pause low suspends, keeps sequence state
// - pause under high clock waits falling edge
// - paused: clock and data ignored
// - resume only when pause rises, clock low
// - pause low releases output immediately
// - guard codes none, quarter, half, whole
// - latch set/clear commands; needed for writes
`timescale 1ns/1ps
`include "spi_eeprom_defines.vh"
module spi_eeprom_node_id #(
   parameter PROG_COUNT = `PROG_CYCLES,
   parameter [23:0] ORG_ID = 24'h00_0000, // arbitrary neutral value
   parameter [23:0] EXT_ID = 24'h00_0001  // arbitrary neutral value
) (
   input  wire mclk,
   input  wire sys_rst,
   input  wire selectN,
   input  wire sck,
   input  wire serialIn,
   input  wire writeProtectN,
   input  wire pauseN,
   output reg  serialOut,
   output reg  serialOutEnN,
   output reg  standby
);
   // phase codes of the serial sequence
   localparam PH_CMD  = 3'd0;
   localparam PH_ADDR = 3'd1;
   localparam PH_RDAT = 3'd2;
   localparam PH_WDAT = 3'd3;
   localparam PH_SRD  = 3'd4;
   localparam PH_SWR  = 3'd5;
   localparam PH_DONE = 3'd6;

   wire       selSyncN;
   wire       sckSync;
   wire       siSync;
   wire       wpSyncN;
   wire       pauseSyncN;

   sync_two_ff #(.RESET_VAL(1'b1)) uSel (.clk(mclk), .rst(sys_rst), .asyncIn(selectN),
      .syncOut(selSyncN));
   sync_two_ff #(.RESET_VAL(1'b0)) uSck (.clk(mclk), .rst(sys_rst), .asyncIn(sck),
      .syncOut(sckSync));
   sync_two_ff #(.RESET_VAL(1'b0)) uSi (.clk(mclk), .rst(sys_rst), .asyncIn(serialIn),
      .syncOut(siSync));
   sync_two_ff #(.RESET_VAL(1'b1)) uWp (.clk(mclk), .rst(sys_rst), .asyncIn(writeProtectN),
      .syncOut(wpSyncN));
   sync_two_ff #(.RESET_VAL(1'b1)) uHold (.clk(mclk), .rst(sys_rst),
      .asyncIn(pauseN), .syncOut(pauseSyncN));

   reg  [7:0]  mem [0:255];
   reg  [7:0]  pageBuf [0:`PAGE_BYTES-1];
   reg         sckPrev_q;
   reg         selPrev_q;
   reg         pausePrev_q;
   reg         armed_q;
   reg         paused_q;
   reg         pausePend_q;
   reg  [2:0]  phase_q;
   reg  [2:0]  bitCnt_q;
   reg  [7:0]  shiftIn_q;
   reg  [7:0]  cmd_q;
   reg  [7:0]  addr_q;
   reg  [7:0]  txByte_q;
   reg  [7:0]  pageBase_q;
   reg  [`PAGE_AW-1:0] pageIdx_q;
   reg  [`PAGE_AW:0]   pageCnt_q;
   reg  [1:0]  newGuard_q;
   reg         byteDone_q;
   reg         wrValid_q;
   reg         progStatus_q;
   reg  [1:0]  guard_q;
   reg         latch_q;
   reg         busy_q;
   reg  [22:0] progCnt_q;
   reg  [`PAGE_AW:0]   copyIdx_q;
   integer     i;

   wire sckRise  = sckSync & ~sckPrev_q;
   wire sckFall  = ~sckSync & sckPrev_q;
   wire selFall  = ~selSyncN & selPrev_q;
   wire selRise  = selSyncN & ~selPrev_q;
   wire pauseFallNow = ~pauseSyncN & pausePrev_q;
   wire pauseRiseNow = pauseSyncN & ~pausePrev_q;
   wire active   = ~selSyncN & armed_q & ~paused_q;
   wire [7:0] nextByte  = {shiftIn_q[6:0], siSync};
   wire [7:0] statusVal = {4'h0, guard_q, latch_q, busy_q};
   // copy starts at the first slot written, so an unaligned start lands right
   wire [`PAGE_AW-1:0] copySlot = pageIdx_q - pageCnt_q[`PAGE_AW-1:0] +
                                  copyIdx_q[`PAGE_AW-1:0];
   wire [7:0] pageAddr  = pageBase_q | {4'h0, copySlot};

   // block guard decode: 00 none, 01 C0-FF, 10 80-FF, 11 all
   function guarded;
      input [7:0] a;
      input [1:0] g;
      begin
         case (g)
            2'b00:   guarded = 1'b0;
            2'b01:   guarded = (a >= `GUARD_QTR_BASE);
            2'b10:   guarded = (a >= `GUARD_HALF_BASE);
            default: guarded = 1'b1;
         endcase
      end
   endfunction

   // factory image: blank array with node identifier on top; a sim-only
   // preload stands in for the factory programming step
   initial begin
      for (i = 0; i < 250; i = i + 1)
         mem[i] = 8'hFF;
      mem[8'hFA] = ORG_ID[23:16];
      mem[8'hFB] = ORG_ID[15:8];
      mem[8'hFC] = ORG_ID[7:0];
      mem[8'hFD] = EXT_ID[23:16];
      mem[8'hFE] = EXT_ID[15:8];
      mem[8'hFF] = EXT_ID[7:0];
   end

   // edge history of synchronised pins
   always @(posedge mclk) begin
      if (sys_rst) begin
         sckPrev_q   <= 1'b0;
         selPrev_q   <= 1'b1;
         pausePrev_q <= 1'b1;
      end else begin
         sckPrev_q   <= sckSync;
         selPrev_q   <= selSyncN;
         pausePrev_q <= pauseSyncN;
      end
   end

   // pause control: entry only with clock low, else deferred to next fall
   always @(posedge mclk) begin
      if (sys_rst || selSyncN) begin
         paused_q    <= 1'b0;
         pausePend_q <= 1'b0;
      end else if (!paused_q) begin
         if (!pauseSyncN && (pauseFallNow || pausePend_q)) begin
            if (!sckSync || sckFall) begin
               paused_q    <= 1'b1;
               pausePend_q <= 1'b0;
            end else begin
               pausePend_q <= 1'b1;
            end
         end else begin
            pausePend_q <= 1'b0;
         end
      end else if (pauseRiseNow && !sckSync) begin
         paused_q <= 1'b0;
      end
   end

   // serial engine, array programming and status bits
   always @(posedge mclk) begin
      if (sys_rst) begin
         armed_q      <= 1'b0;
         phase_q      <= PH_CMD;
         bitCnt_q     <= 3'd0;
         shiftIn_q    <= 8'h00;
         cmd_q        <= 8'h00;
         addr_q       <= 8'h00;
         txByte_q     <= 8'h00;
         pageBase_q   <= 8'h00;
         pageIdx_q    <= {`PAGE_AW{1'b0}};
         pageCnt_q    <= {(`PAGE_AW+1){1'b0}};
         newGuard_q   <= 2'b00;
         byteDone_q   <= 1'b0;
         wrValid_q    <= 1'b0;
         progStatus_q <= 1'b0;
         guard_q      <= `BP_RESET;
         latch_q      <= 1'b0;
         busy_q       <= 1'b0;
         progCnt_q    <= 23'd0;
         copyIdx_q    <= {(`PAGE_AW+1){1'b0}};
      end else begin
         // programming runs regardless of select or write-protect
         if (busy_q) begin
            if (!progStatus_q && copyIdx_q < pageCnt_q) begin
               mem[pageAddr] <= pageBuf[copySlot];
               copyIdx_q     <= copyIdx_q + 1'b1;
            end
            if (progCnt_q == PROG_COUNT[22:0] - 23'd1) begin
               busy_q    <= 1'b0;
               latch_q   <= 1'b0;
               progCnt_q <= 23'd0;
               if (progStatus_q)
                  guard_q <= newGuard_q;
            end else begin
               progCnt_q <= progCnt_q + 23'd1;
            end
         end
         // write-protect low clears the latch at any time
         if (!wpSyncN)
            latch_q <= 1'b0;
         // first select low after power-up arms the engine
         if (selFall)
            armed_q <= 1'b1;
         if (selSyncN) begin
            // deselect: commit complete write or abandon
            phase_q  <= PH_CMD;
            bitCnt_q <= 3'd0;
            if (selRise && wrValid_q && !busy_q && latch_q && wpSyncN) begin
               busy_q    <= 1'b1;
               progCnt_q <= 23'd0;
               copyIdx_q <= {(`PAGE_AW+1){1'b0}};
            end // otherwise nothing starts
            wrValid_q <= 1'b0;
         end else if (active && sckRise) begin
            // sample input on rising clock
            shiftIn_q <= nextByte;
            bitCnt_q  <= bitCnt_q + 3'd1;
            byteDone_q <= (bitCnt_q == 3'd7);
            wrValid_q  <= 1'b0; // a partial extra bit spoils the write
            if (bitCnt_q == 3'd7) begin
               case (phase_q)
                  PH_CMD: begin
                     cmd_q <= nextByte & `OP_MASK;
                     case (nextByte & `OP_MASK)
                        `OP_READ, `OP_WRITE: phase_q <= PH_ADDR;
                        `OP_STATUS_RD: begin
                           phase_q  <= PH_SRD;
                           txByte_q <= statusVal;
                        end
                        `OP_STATUS_WR: phase_q <= PH_SWR;
                        `OP_LATCH_SET: begin
                           if (!busy_q && wpSyncN)
                              latch_q <= 1'b1;
                           phase_q <= PH_DONE;
                        end
                        `OP_LATCH_CLR: begin
                           if (!busy_q)
                              latch_q <= 1'b0;
                           phase_q <= PH_DONE;
                        end
                        default: phase_q <= PH_DONE;
                     endcase
                  end
                  PH_ADDR: begin
                     addr_q     <= nextByte;
                     pageBase_q <= {nextByte[7:4], 4'h0};
                     pageIdx_q  <= nextByte[3:0];
                     pageCnt_q  <= {(`PAGE_AW+1){1'b0}};
                     txByte_q   <= mem[nextByte];
                     phase_q    <= (cmd_q == `OP_READ) ? PH_RDAT : PH_WDAT;
                  end
                  PH_RDAT: begin
                     addr_q   <= addr_q + 8'd1;
                     txByte_q <= mem[addr_q + 8'd1];
                  end
                  PH_WDAT: begin
                     // page wraps within its 16 bytes
                     pageBuf[pageIdx_q] <= nextByte;
                     pageIdx_q <= pageIdx_q + 1'b1;
                     if (pageCnt_q != `PAGE_BYTES)
                        pageCnt_q <= pageCnt_q + 1'b1;
                     progStatus_q <= 1'b0;
                     wrValid_q <= !busy_q && !guarded(pageBase_q, guard_q);
                  end
                  PH_SRD: txByte_q <= statusVal;
                  PH_SWR: begin
                     newGuard_q   <= nextByte[`ST_BP1:`ST_BP0];
                     progStatus_q <= 1'b1;
                     pageCnt_q    <= {(`PAGE_AW+1){1'b0}};
                     wrValid_q    <= !busy_q;
                     phase_q      <= PH_DONE;
                  end
                  default: phase_q <= PH_DONE;
               endcase
            end
         end
      end
   end

   // serial output: updated after falling clock, released when idle
   always @(posedge mclk) begin
      if (sys_rst) begin
         serialOut    <= 1'b0;
         serialOutEnN <= 1'b1;
         standby      <= 1'b1;
      end else begin
         standby <= selSyncN & ~busy_q;
         if (selSyncN || !pauseSyncN || paused_q || !armed_q) begin
            serialOutEnN <= 1'b1;
         end else if (!sckSync && (byteDone_q || bitCnt_q != 3'd0) &&
                      (phase_q == PH_RDAT || phase_q == PH_SRD)) begin
            // bit moves only while the clock is low, so after its fall; a
            // resumed pause drives again the bit it interrupted
            serialOut    <= txByte_q[3'd7 - bitCnt_q];
            serialOutEnN <= 1'b0;
         end
      end
   end

endmodule

// File: verilog/spi_eeprom_defines.vh
/*
 * constants for the serial eeprom with node identifier: opcodes, status
 * bit positions, factory values and timing counts.
 * assumes a 25 MHz system clock sampling all serial pins.
 */
`ifndef SPI_EEPROM_DEFINES_VH
`define SPI_EEPROM_DEFINES_VH

// instruction codes, bit 3 is a don't-care and is masked before compare
`define OP_READ        8'h03
`define OP_WRITE       8'h02
`define OP_LATCH_CLR   8'h04
`define OP_LATCH_SET   8'h06
`define OP_STATUS_RD   8'h05
`define OP_STATUS_WR   8'h01
`define OP_MASK        8'hF7

// status field positions
`define ST_WIP         0
`define ST_WEL         1
`define ST_BP0         2
`define ST_BP1         3

// factory block guard: upper quarter protected
`define BP_RESET       2'b01

// node identifier location
`define NODE_ID_BASE   8'hFA
`define NODE_ID_LAST   8'hFF

// protected region starts for the quarter and half guard settings
`define GUARD_QTR_BASE 8'hC0
`define GUARD_HALF_BASE 8'h80

// page size in bytes and index width
`define PAGE_BYTES     16
`define PAGE_AW        4

// self-timed programming time, microseconds, and clock rate in MHz
`define PROG_TIME_US   5000
`define MCLK_MHZ       25
`define PROG_CYCLES    (`PROG_TIME_US * `MCLK_MHZ)

`endif

// File: verilog/sync_two_ff.v
/*
 * two-flop level synchroniser for one pin.
 * assumes the input is asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/1ps
module sync_two_ff #(
   parameter RESET_VAL = 1'b0
) (
   input  wire clk,
   input  wire rst,
   input  wire asyncIn,
   output reg  syncOut
);
   reg stage1;

   // first stage feeds only the second stage
   always @(posedge clk) begin
      if (rst) begin
         stage1  <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// File: testbench/spi_eeprom_node_id_properties.sv
/* timing checks on the eeprom serial pins, attached by bind.
   assumes sck far slower than mclk and every pin synchronised in two flops. */
`timescale 1ns/1ps
module spi_eeprom_node_id_properties #(
   parameter PROG_COUNT = 50
) (
   input wire mclk,
   input wire sys_rst,
   input wire selectN,
   input wire sck,
   input wire serialIn,
   input wire writeProtectN,
   input wire pauseN,
   input wire serialOut,
   input wire serialOutEnN,
   input wire standby
);
   reg     selPrevQ, idleQ, wpLowQ, clockedQ;
   integer lowCntQ;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // frame history; frames that open during a write are left out, it may still run
   always @(posedge mclk) begin
      selPrevQ <= selectN;
      lowCntQ <= (selectN && !standby) ? lowCntQ + 1 : 0;
      if (selPrevQ && !selectN) begin
         idleQ <= standby;
         wpLowQ <= !writeProtectN;
         clockedQ <= 1'b0;
      end else if (!selectN) begin
         wpLowQ <= wpLowQ && !writeProtectN;
         clockedQ <= clockedQ || sck;
      end
   end
   sequence s_quiet;
      standby [*3];
   endsequence
   sequence s_endFrame;
      $rose(selectN) && idleQ;
   endsequence
   property p_deselRelease;
      selectN [*5] |-> serialOutEnN;
   endproperty
   property p_pauseRelease;
      !pauseN [*5] |-> serialOutEnN;
   endproperty
   property p_selActive;
      !selectN [*6] |-> !standby;
   endproperty
   property p_progBound;
      lowCntQ <= PROG_COUNT + 8;
   endproperty
   property p_wpNoProg;
      s_endFrame ##0 wpLowQ |-> ##[3:8] s_quiet;
   endproperty
   property p_idleFrame;
      s_endFrame ##0 !clockedQ |-> ##[3:8] s_quiet;
   endproperty
   property p_standbyRise;
      $rose(standby) |-> selectN && $past(selectN, 2);
   endproperty
   property p_outChange;
      !serialOutEnN && !$past(serialOutEnN) && $changed(serialOut) |-> !sck;
   endproperty
   a_deselRelease: assert property (p_deselRelease) else $error("out driven deselected");
   a_pauseRelease: assert property (p_pauseRelease) else $error("out driven paused");
   a_selActive: assert property (p_selActive) else $error("standby while selected");
   a_progBound: assert property (p_progBound) else $error("programming overran");
   a_wpNoProg: assert property (p_wpNoProg) else $error("write under protect");
   a_idleFrame: assert property (p_idleFrame) else $error("empty frame wrote");
   a_standbyRise: assert property (p_standbyRise) else $error("standby while selected");
   a_outChange: assert property (p_outChange) else $error("out moved with sck high");
endmodule

// File: testbench/spi_host_model.sv
/* host on the serial bus: bytes msb first on a 320 ns clock, sck idle low.
   assumes the bench calls its tasks just after an mclk edge. */
`timescale 1ns/1ps
module spi_host_model (
   input  wire       mclk,
   input  wire       serialOut,
   input  wire       serialOutEnN,
   output reg        selectN,
   output reg        sck,
   output reg        serialIn,
   output reg        rxStb,
   output reg  [7:0] rxByte
);
   reg  want;
   reg  lastSo;
   // a released line shows the inverse of the last bit, never a stale copy
   wire soLine = serialOutEnN ? ~lastSo : serialOut;
   initial begin
      {selectN, sck, serialIn, rxStb, rxByte, want, lastSo} = 14'h2000;
   end
   always @(posedge mclk) if (!serialOutEnN) lastSo <= serialOut;
   task wt(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   // select moves only with sck low
   task sel;
      selectN <= 1'b0;
      wt(4);
   endtask
   task desel;
      selectN <= 1'b1;
      wt(4);
   endtask
   // bit set five cycles ahead of the rise, sampled back as sck rises
   task xb(input [7:0] t);
      integer   i;
      reg [7:0] r;
      for (i = 7; i >= 0; i = i - 1) begin
         serialIn <= t[i];
         wt(5);
         r[i] = soLine;
         sck <= 1'b1;
         wt(3);
         sck <= 1'b0;
      end
      rxByte <= r;
      rxStb <= want;
      wt(1);
      rxStb <= 1'b0;
   endtask
endmodule

// File: testbench/test_spi_eeprom_node_id.sv
/* bench of the eeprom serial block: host model frames, reads checked by queue.
   assumes programming shortened to PROG cycles through PROG_COUNT. */
`timescale 1ns/1ps
`include "spi_eeprom_defines.vh"
module test_spi_eeprom_node_id;
   localparam PROG = 400;
   localparam [23:0] ORG = 24'h3C_5A17; // arbitrary value
   localparam [23:0] EXT = 24'h9E_0B44; // arbitrary value
   reg        mclk, sys_rst, writeProtectN, pauseN;
   wire       selectN, sck, serialIn, serialOut, serialOutEnN, standby, rxStb;
   wire [7:0] rxByte;
   reg  [7:0] q[$];
   reg  [7:0] d, b;
   integer    num_errors, comparisons, cyc, g, i;
   spi_eeprom_node_id #(.PROG_COUNT(PROG), .ORG_ID(ORG), .EXT_ID(EXT)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .selectN(selectN), .sck(sck),
      .serialIn(serialIn), .writeProtectN(writeProtectN), .pauseN(pauseN),
      .serialOut(serialOut), .serialOutEnN(serialOutEnN), .standby(standby));
   spi_host_model host (.mclk(mclk), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
      .selectN(selectN), .sck(sck), .serialIn(serialIn), .rxStb(rxStb), .rxByte(rxByte));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task chk(input [7:0] seen, input [7:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // note the byte due, then clock it out of the device
   task getb(input [7:0] e);
      q.push_back(e);
      host.want = 1'b1;
      host.xb(8'($urandom));
      host.want = 1'b0;
   endtask
   task op1(input [7:0] op);
      host.sel;
      host.xb(op);
      host.desel;
   endtask
   task rdst(input [7:0] e);
      host.sel;
      host.xb(`OP_STATUS_RD);
      getb(e);
      host.desel;
   endtask
   task rdm(input [7:0] a, input [7:0] e);
      host.sel;
      host.xb(`OP_READ);
      host.xb(a);
      getb(e);
      host.desel;
   endtask
   // latch set, then one write frame; a status write has no address byte
   task wr(input [7:0] op, input [7:0] a, input [7:0] v);
      op1(`OP_LATCH_SET);
      host.sel;
      host.xb(op);
      if (op == `OP_WRITE)
         host.xb(a);
      host.xb(v);
      host.desel;
   endtask
   // programming must end within its count; a refused write never lowers standby
   task idle;
      integer n;
      host.wt(6);
      for (n = 0; n < PROG + 50 && standby !== 1'b1; n = n + 1)
         host.wt(1);
      chk({7'h00, standby}, 8'h01);
   endtask
   task noprog;
      host.wt(8);
      chk({7'h00, standby}, 8'h01);
   endtask
   // read results taken oldest first; the cycle count cuts a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rxStb === 1'b1)
         chk(rxByte, q.pop_front());
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   initial begin
      {num_errors, comparisons, cyc} = 0;
      {sys_rst, writeProtectN, pauseN} = 3'h7;
      void'($urandom(26781));
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      host.wt(3);
      chk({6'h00, serialOutEnN, standby}, 8'h03);
      host.sel;
      host.wt(8);
      host.desel;
      noprog;
      rdst(8'h04);
      wr(`OP_WRITE, `NODE_ID_BASE, 8'h55);
      noprog;
      host.sel;
      host.xb(`OP_READ);
      host.xb(`NODE_ID_BASE);
      for (i = 0; i < 6; i = i + 1)
         getb(8'({ORG, EXT} >> (40 - 8 * i)));
      host.desel;
      // accepted write: busy while deselected, latch dropped at the end
      d = 8'($urandom);
      wr(`OP_WRITE, 8'h10, d);
      host.wt(8);
      chk({7'h00, standby}, 8'h00);
      rdst(8'h07);
      idle;
      rdst(8'h04);
      rdm(8'h10, d);
      // deselect after the address byte abandons the write, latch kept
      op1(`OP_LATCH_SET);
      host.sel;
      host.xb(`OP_WRITE);
      host.xb(8'h10);
      host.desel;
      noprog;
      rdst(8'h06);
      op1(`OP_LATCH_CLR);
      rdst(8'h04);
      writeProtectN <= 1'b0;
      wr(`OP_WRITE, 8'h10, ~d);
      noprog;
      rdst(8'h04);
      writeProtectN <= 1'b1;
      rdm(8'h10, d);
      // every guard code, probed at 0xB0 which only half and whole cover
      for (g = 0; g < 4; g = g + 1) begin
         wr(`OP_STATUS_WR, 8'h00, {4'h0, g[1:0], 2'b00});
         idle;
         rdst({4'h0, g[1:0], 2'b00});
         d = 8'($urandom);
         wr(`OP_WRITE, 8'hB0, d);
         if (g < 2)
            b = d;
         idle;
         rdm(8'hB0, b);
      end
      // pause mid-read: output let go, clocks ignored, read picks up again
      host.sel;
      host.xb(`OP_READ);
      host.xb(`NODE_ID_BASE);
      pauseN <= 1'b0;
      host.wt(6);
      chk({7'h00, serialOutEnN}, 8'h01);
      host.xb(8'($urandom));
      pauseN <= 1'b1;
      host.wt(4);
      getb(ORG[23:16]);
      host.desel;
      close_out;
   end
endmodule
bind spi_eeprom_node_id spi_eeprom_node_id_properties #(.PROG_COUNT(PROG_COUNT)) props (
   .mclk(mclk), .sys_rst(sys_rst), .selectN(selectN), .sck(sck),
   .serialIn(serialIn), .writeProtectN(writeProtectN), .pauseN(pauseN),
   .serialOut(serialOut), .serialOutEnN(serialOutEnN), .standby(standby));
